// ---- core/ntl_pkg.sv ----
// Purpose: Constants and types for the NT line control register pair
// Assumes: AHB-Lite register bus, 32-bit data, one word per register
// Notes: Bit positions count from bit 7 down to bit 0
package ntl_pkg;
    localparam logic [7:0] NTL_CTRL_OFFSET = 8'h08;
    localparam logic [7:0] NTL_STAT_OFFSET = 8'h0C;
    localparam logic [7:0] NTL_CTRL_RESET = 8'h00;
    localparam logic [7:0] NTL_DIAG_RESET = 8'h00;
    // Control register fields
    localparam int NTL_ACT_REQ_BIT = 7;
    localparam int NTL_DEACT_REQ_BIT = 6;
    localparam int NTL_DCHAN_B1_BIT = 5;
    localparam int NTL_TIMING_BIT = 4;
    localparam int NTL_MS_BIT = 3;
    localparam int NTL_HALF_BIT = 2;
    localparam int NTL_TXMF_BIT = 1;
    localparam int NTL_PAGE_BIT = 0;
    // Diagnostic register fields
    localparam int NTL_LOOP_HI = 7;
    localparam int NTL_LOOP_LO = 6;
    localparam int NTL_FLOCK_BIT = 5;
    localparam int NTL_FVOFF_BIT = 4;
    localparam int NTL_IDLE_BIT = 3;
    localparam int NTL_ECHO_BIT = 2;
    localparam int NTL_SLAVE_BIT = 1;
    // Frame sync needs this many clean framing sequences
    localparam logic [1:0] NTL_SYNC_COUNT = 2'h3;
    typedef enum logic [1:0] {
        NTL_LOOP_NONE,
        NTL_LOOP_NEAR,
        NTL_LOOP_DIGITAL,
        NTL_LOOP_REMOTE
    } ntl_loop_t;
    typedef enum {
        NTL_LINK_DOWN,
        NTL_LINK_ACTIVATING,
        NTL_LINK_UP,
        NTL_LINK_DEACTIVATING
    } ntl_link_t;
endpackage

// ---- core/ntl_sync2.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Input asynchronous to ref_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module ntl_sync2 (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic meta;
        logic stable;
    } ntl_sync_t;
    ntl_sync_t st_ff;
    ntl_sync_t nxt_st;
    always_comb begin
        nxt_st.meta = din;
        nxt_st.stable = st_ff.meta;
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign dout = st_ff.stable;
endmodule

// ---- core/ntl_frame_sync.sv ----
// Purpose: Receive frame lock detector
// Assumes: One framing check pulse per received frame
// Notes: Lock holds through errors when hold is set
`timescale 1ns/1ps
module ntl_frame_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frame_check,
    input wire logic frame_ok,
    input wire logic hold_frame_lock,
    input wire logic link_up,
    output logic locked
);
    typedef struct packed {
        logic [1:0] good;
        logic locked;
    } ntl_fs_t;
    ntl_fs_t st_ff;
    ntl_fs_t nxt_st;
    always_comb begin
        nxt_st = st_ff;
        if (!link_up) begin
            nxt_st = '0;
        end else if (frame_check) begin
            if (frame_ok) begin
                if (st_ff.good != ntl_pkg::NTL_SYNC_COUNT) begin
                    nxt_st.good = st_ff.good + 2'h1;
                end
                if (st_ff.good + 2'h1 >= ntl_pkg::NTL_SYNC_COUNT) begin
                    nxt_st.locked = 1'b1;
                end
            end else if (!hold_frame_lock) begin
                nxt_st.good = 2'h0;
                nxt_st.locked = 1'b0;
            end
            // Hold keeps lock and count on a lost framing sequence
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign locked = st_ff.locked;
endmodule

// ---- core/ntl_regs.sv ----
// Purpose: NT line control and diagnostic registers with frame-sampled controls
// Assumes: AHB-Lite slave, single word transfers, 40 MHz ref_clk
// Notes: Registers are write-only; a status word shows the block's state
`timescale 1ns/1ps
// How it works
// - Activation request one starts bringing the line up; zero keeps state.
// - Deactivation request one takes line down; wins over activation.
// - D-in-B1 set carries D-channel in B1 at 64 kbit/s, else 16.
// - Timing zero selects fixed timing; one selects adaptive compensation.
// - M/S control bit goes out as M when half is zero, S otherwise; here it drives multiframe_bit in both halves.
// - Half bit selects transmitted frame half, same as the dedicated pin.
// - Send-multiframe with half zero sends aux framing 1, N 0; else 0, 1.
// - Data bit zero steers a write: control or diagnostic register.
// - Control sampled once per frame; last write in a frame wins.
// - Loop field: none, near-end, digital, or remote loopback.
// - Hold-frame-lock keeps sync and INFO when framing is lost.
// - Without hold, sync declared after three clean framing sequences.
// - Framing-violation-off stops frame sync breaking the bipolar violation rule.
// - Idle test bit forces continuous all-ones on the line.
// - Echo test bit forces every transmitted echo bit to zero.
// - Slave bit makes the device an NT slave on external clocks.
// - Diagnostic register reached by control address with data bit zero set.
module ntl_regs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic frame_pulse,
    input wire logic half_pin,
    input wire logic rx_frame_check,
    input wire logic rx_frame_ok,
    input wire logic line_receive,
    input wire logic serial_stream_in,
    input wire logic tx_data_bit,
    input wire logic rx_d_bit,
    input wire logic ext_clk_en,
    output logic line_transmit,
    output logic line_violation,
    output logic serial_stream_out,
    output logic echo_bit,
    output logic multiframe_bit,
    output logic auxiliary_framing_bit,
    output logic n_bit,
    output logic frame_half,
    output logic dchan_in_first_bslot,
    output logic adaptive_timing,
    output logic nt_slave,
    output logic link_active,
    output logic frame_locked
);
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] ctrl_shadow;
        logic ctrl_dirty;
        logic [7:0] ctrl;
        logic [7:0] diag;
        logic activate;
        logic deactivate;
        ntl_pkg::ntl_link_t link;
        logic [31:0] rdata;
        logic tx;
        logic viol;
        logic sso;
        logic echo;
        logic msbit;
        logic auxf;
        logic nbit;
        logic half;
        logic dchan_b1;
        logic timing;
        logic slave;
        logic active;
        logic locked;
        logic frame_seen;
    } ntl_state_t;

    ntl_state_t st_ff;
    ntl_state_t nxt_st;
    logic frame_s;
    logic half_s;
    logic rxl_s;
    logic ssi_s;
    logic chk_s;
    logic ok_s;
    logic extc_s;
    logic lock_w;
    logic frame_tick;
    logic [6:0] pin_raw;
    logic [6:0] pin_sync;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = (a[7:2] == off[7:2]);
    endfunction

    // One two-flop stage per pin; only the second flop reads the first
    assign pin_raw = {ext_clk_en, rx_frame_ok, rx_frame_check, serial_stream_in,
        line_receive, half_pin, frame_pulse};
    for (genvar gi = 0; gi < 7; gi++) begin : g_pin_sync
        ntl_sync2 u_sync (.ref_clk(ref_clk), .reset(reset), .din(pin_raw[gi]), .dout(pin_sync[gi]));
    end
    assign frame_s = pin_sync[0];
    assign half_s = pin_sync[1];
    assign rxl_s = pin_sync[2];
    assign ssi_s = pin_sync[3];
    assign chk_s = pin_sync[4];
    assign ok_s = pin_sync[5];
    assign extc_s = pin_sync[6];

    // Frame edge from the synchronised frame clock
    assign frame_tick = frame_s & ~st_ff.frame_seen;

    ntl_frame_sync u_lock (
        .ref_clk(ref_clk),
        .reset(reset),
        .frame_check(chk_s),
        .frame_ok(ok_s),
        .hold_frame_lock(st_ff.diag[ntl_pkg::NTL_FLOCK_BIT]),
        .link_up(st_ff.link != ntl_pkg::NTL_LINK_DOWN),
        .locked(lock_w)
    );

    always_comb begin
        logic [7:0] wd;
        logic loop_near;
        logic loop_dig;
        logic loop_rem;
        logic half_eff;
        logic line_bit;
        logic ctrl_wr;
        wd = hwdata[7:0];
        nxt_st = st_ff;
        nxt_st.frame_seen = frame_s;
        ctrl_wr = 1'b0;
        loop_near = 1'b0;
        loop_dig = 1'b0;
        loop_rem = 1'b0;
        half_eff = 1'b0;
        line_bit = 1'b0;
        // Address phase captured when the bus is ready
        nxt_st.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            nxt_st.wr_pend = hwrite;
            nxt_st.wr_addr = haddr;
            nxt_st.rdata = 32'h0000_0000;
            if (!hwrite && addr_hit(haddr, ntl_pkg::NTL_STAT_OFFSET)) begin
                nxt_st.rdata = {24'h00_0000, st_ff.locked, st_ff.active,
                    st_ff.activate, st_ff.deactivate, 2'(st_ff.link), 2'h0};
            end
        end
        // Data phase write; data bit zero picks the page
        if (st_ff.wr_pend && addr_hit(st_ff.wr_addr, ntl_pkg::NTL_CTRL_OFFSET)) begin
            if (wd[ntl_pkg::NTL_PAGE_BIT]) begin
                nxt_st.diag = wd;
            end else begin
                nxt_st.ctrl_shadow = wd;
                nxt_st.ctrl_dirty = 1'b1;
                ctrl_wr = 1'b1;
            end
        end
        // Link state, deactivation has priority; zeros keep state
        if (frame_tick) begin
            case (st_ff.link)
                ntl_pkg::NTL_LINK_DOWN: begin
                    if (!st_ff.deactivate && st_ff.activate) begin
                        nxt_st.link = ntl_pkg::NTL_LINK_ACTIVATING;
                    end
                end
                ntl_pkg::NTL_LINK_ACTIVATING: begin
                    if (st_ff.deactivate) begin
                        nxt_st.link = ntl_pkg::NTL_LINK_DEACTIVATING;
                    end else if (lock_w) begin
                        nxt_st.link = ntl_pkg::NTL_LINK_UP;
                    end
                end
                ntl_pkg::NTL_LINK_UP: begin
                    if (st_ff.deactivate) begin
                        nxt_st.link = ntl_pkg::NTL_LINK_DEACTIVATING;
                    end else if (!lock_w) begin
                        nxt_st.link = ntl_pkg::NTL_LINK_ACTIVATING;
                    end
                end
                ntl_pkg::NTL_LINK_DEACTIVATING: begin
                    nxt_st.link = ntl_pkg::NTL_LINK_DOWN;
                end
                default: begin
                    nxt_st.link = ntl_pkg::NTL_LINK_DOWN;
                end
            endcase
            if (st_ff.activate || st_ff.deactivate) begin
                nxt_st.activate = 1'b0;
                nxt_st.deactivate = 1'b0;
            end
        end
        // Latched once per frame, after the consume, so a fresh request is never lost
        if (frame_tick && st_ff.ctrl_dirty) begin
            nxt_st.ctrl = st_ff.ctrl_shadow;
            nxt_st.ctrl_dirty = ctrl_wr;
            nxt_st.activate = st_ff.ctrl_shadow[ntl_pkg::NTL_ACT_REQ_BIT];
            nxt_st.deactivate = st_ff.ctrl_shadow[ntl_pkg::NTL_DEACT_REQ_BIT];
        end
        // Half pin and half bit act alike; either selects the second half
        half_eff = st_ff.ctrl[ntl_pkg::NTL_HALF_BIT] | half_s;
        nxt_st.half = half_eff;
        nxt_st.dchan_b1 = st_ff.ctrl[ntl_pkg::NTL_DCHAN_B1_BIT];
        nxt_st.timing = st_ff.ctrl[ntl_pkg::NTL_TIMING_BIT];
        nxt_st.slave = st_ff.diag[ntl_pkg::NTL_SLAVE_BIT] & extc_s;
        nxt_st.msbit = st_ff.ctrl[ntl_pkg::NTL_MS_BIT];
        if (!half_eff && st_ff.ctrl[ntl_pkg::NTL_TXMF_BIT]) begin
            nxt_st.auxf = 1'b1;
            nxt_st.nbit = 1'b0;
        end else begin
            nxt_st.auxf = 1'b0;
            nxt_st.nbit = 1'b1;
        end
        // Loopback path select
        loop_near = (st_ff.diag[ntl_pkg::NTL_LOOP_HI:ntl_pkg::NTL_LOOP_LO] == 2'(ntl_pkg::NTL_LOOP_NEAR));
        loop_dig = (st_ff.diag[ntl_pkg::NTL_LOOP_HI:ntl_pkg::NTL_LOOP_LO] == 2'(ntl_pkg::NTL_LOOP_DIGITAL));
        loop_rem = (st_ff.diag[ntl_pkg::NTL_LOOP_HI:ntl_pkg::NTL_LOOP_LO] == 2'(ntl_pkg::NTL_LOOP_REMOTE));
        line_bit = loop_rem ? rxl_s : tx_data_bit;
        if (st_ff.diag[ntl_pkg::NTL_IDLE_BIT]) begin
            line_bit = 1'b1;
        end
        nxt_st.tx = line_bit;
        // Framing bit as a violation unless suppressed
        nxt_st.viol = ~st_ff.diag[ntl_pkg::NTL_FVOFF_BIT] & ~st_ff.diag[ntl_pkg::NTL_IDLE_BIT];
        if (loop_dig) begin
            nxt_st.sso = ssi_s;
        end else if (loop_near) begin
            nxt_st.sso = line_bit;
        end else begin
            nxt_st.sso = rxl_s;
        end
        // Echo mirrors received D unless forced low
        nxt_st.echo = st_ff.diag[ntl_pkg::NTL_ECHO_BIT] ? 1'b0 : rx_d_bit;
        nxt_st.active = (st_ff.link == ntl_pkg::NTL_LINK_UP);
        nxt_st.locked = lock_w;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.ctrl <= ntl_pkg::NTL_CTRL_RESET;
            st_ff.ctrl_shadow <= ntl_pkg::NTL_CTRL_RESET;
            st_ff.diag <= ntl_pkg::NTL_DIAG_RESET;
            st_ff.link <= ntl_pkg::NTL_LINK_DOWN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Zero wait states; a write lands in the cycle after its data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign line_transmit = st_ff.tx;
    assign line_violation = st_ff.viol;
    assign serial_stream_out = st_ff.sso;
    assign echo_bit = st_ff.echo;
    assign multiframe_bit = st_ff.msbit;
    assign auxiliary_framing_bit = st_ff.auxf;
    assign n_bit = st_ff.nbit;
    assign frame_half = st_ff.half;
    assign dchan_in_first_bslot = st_ff.dchan_b1;
    assign adaptive_timing = st_ff.timing;
    assign nt_slave = st_ff.slave;
    assign link_active = st_ff.active;
    assign frame_locked = st_ff.locked;
endmodule

// ---- tb/ntl_regs_monitor.sv ----
// Purpose: Port assertions for ntl_regs
// Assumes: One clock domain, async active-high reset
// Notes: Frame-sampled outputs may only move shortly after a frame edge
`timescale 1ns/1ps
module ntl_regs_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic frame_pulse,
    input wire logic half_pin,
    input wire logic ext_clk_en,
    input wire logic auxiliary_framing_bit,
    input wire logic n_bit,
    input wire logic frame_half,
    input wire logic dchan_in_first_bslot,
    input wire logic adaptive_timing,
    input wire logic nt_slave,
    input wire logic link_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic fp_ff;
    logic [3:0] since_ff;
    logic rd_take;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    // Cycles since the raw frame edge, saturating so it never wraps into a false pass
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fp_ff <= 1'b0;
            since_ff <= 4'hF;
        end else begin
            fp_ff <= frame_pulse;
            since_ff <= (frame_pulse && !fp_ff) ? 4'h0 : ((since_ff == 4'hF) ? since_ff : since_ff + 4'h1);
        end
    end
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    ctrl_rd_zero_a: assert property (rd_take && haddr == ntl_pkg::NTL_CTRL_OFFSET |=> hrdata == 32'h0)
        else $error("control register readable");
    unmapped_zero_a: assert property (rd_take && haddr != ntl_pkg::NTL_CTRL_OFFSET
        && haddr != ntl_pkg::NTL_STAT_OFFSET |=> hrdata == 32'h0) else $error("unmapped read not zero");
    aux_n_pair_a: assert property (!$past(reset) && !frame_half |-> auxiliary_framing_bit != n_bit)
        else $error("aux framing and N bits not complementary");
    slave_clk_a: assert property (!ext_clk_en [*4] |=> !nt_slave)
        else $error("slave mode without external clock");
    ctrl_frame_a: assert property ($changed(dchan_in_first_bslot) || $changed(adaptive_timing) |-> since_ff <= 4'hA)
        else $error("control output moved away from frame edge");
    link_step_a: assert property ($rose(link_active) |-> since_ff <= 4'hA)
        else $error("link came up away from frame edge");
    half_pin_a: assert property (half_pin [*4] |=> frame_half)
        else $error("half pin ignored");
    cover property (rd_take);
    cover property ($rose(link_active));
    cover property ($rose(nt_slave));
endmodule
bind ntl_regs ntl_regs_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_pulse(frame_pulse), .half_pin(half_pin), .ext_clk_en(ext_clk_en),
    .auxiliary_framing_bit(auxiliary_framing_bit), .n_bit(n_bit), .frame_half(frame_half),
    .dchan_in_first_bslot(dchan_in_first_bslot), .adaptive_timing(adaptive_timing), .nt_slave(nt_slave),
    .link_active(link_active));

// ---- tb/ntl_te_model.sv ----
// Purpose: Remote terminal model on the line side
// Assumes: One framing sequence per system frame
// Notes: Ok line wanders outside checks so it is never read stale
`timescale 1ns/1ps
module ntl_te_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frame_pulse,
    input wire logic good_framing,
    input wire logic line_level,
    output logic rx_frame_check,
    output logic rx_frame_ok,
    output logic line_receive
);
    logic fp_ff;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fp_ff <= 1'b0;
            rx_frame_check <= 1'b0;
            rx_frame_ok <= 1'b0;
        end else begin
            fp_ff <= frame_pulse;
            rx_frame_check <= frame_pulse && !fp_ff;
            rx_frame_ok <= (frame_pulse && !fp_ff) ? good_framing : !rx_frame_ok;
        end
    end
    assign line_receive = line_level;
endmodule

// ---- tb/tb_nt_line_control_regs.sv ----
// Purpose: Self-checking bench for ntl_regs
// Assumes: AHB-Lite master, single slave, 40 MHz clock
// Notes: Control table first, then link, diagnostic and loop cases
`timescale 1ns/1ps
module tb_nt_line_control_regs;
    logic ref_clk, reset, hsel, hwrite, frame_pulse, half_pin, serial_stream_in, tx_data_bit, ext_clk_en;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic hreadyout, hresp, rx_frame_check, rx_frame_ok, line_receive, good, level;
    logic line_transmit, line_violation, serial_stream_out, echo_bit, multiframe_bit, auxiliary_framing_bit, n_bit;
    logic frame_half, dchan_in_first_bslot, adaptive_timing, nt_slave, link_active, frame_locked;
    logic rx_d_bit = 1'b0;
    int n_fail = 0, checks_done = 0, cyc = 0, viol = 0;
    // Control byte, then dchan, timing, m/s, half, aux framing, N
    logic [13:0] rows [6] = '{14'h0821, 14'h0411, 14'h028A, 14'h0105, 14'h0E39, 14'h0001};
    ntl_regs dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .frame_pulse(frame_pulse), .half_pin(half_pin), .rx_frame_check(rx_frame_check), .rx_frame_ok(rx_frame_ok),
        .line_receive(line_receive), .serial_stream_in(serial_stream_in), .tx_data_bit(tx_data_bit),
        .rx_d_bit(rx_d_bit), .ext_clk_en(ext_clk_en), .line_transmit(line_transmit), .line_violation(line_violation),
        .serial_stream_out(serial_stream_out), .echo_bit(echo_bit), .multiframe_bit(multiframe_bit),
        .auxiliary_framing_bit(auxiliary_framing_bit), .n_bit(n_bit), .frame_half(frame_half),
        .dchan_in_first_bslot(dchan_in_first_bslot), .adaptive_timing(adaptive_timing), .nt_slave(nt_slave),
        .link_active(link_active), .frame_locked(frame_locked));
    ntl_te_model te (.ref_clk(ref_clk), .reset(reset), .frame_pulse(frame_pulse), .good_framing(good),
        .line_level(level), .rx_frame_check(rx_frame_check), .rx_frame_ok(rx_frame_ok), .line_receive(line_receive));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Forced-low echo must ignore received D bits, so keep them moving
    always @(posedge ref_clk) begin
        rx_d_bit <= ~rx_d_bit;
        cyc <= cyc + 1;
        if (line_violation === 1'b1) viol <= viol + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic frame(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            frame_pulse <= 1'b1;
            repeat (4) @(posedge ref_clk);
            frame_pulse <= 1'b0;
            repeat (16) @(posedge ref_clk);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        {hsel, hwrite, frame_pulse, half_pin, serial_stream_in, tx_data_bit, ext_clk_en, level} = 8'h00;
        {haddr, htrans, hsize, hwdata, good} = {8'h00, 2'h0, 3'h2, 32'h0, 1'b1};
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("n_bit", n_bit, 1);
        chk("link", link_active, 0);
        for (int i = 0; i < 6; i++) begin
            bus(1, 8'h08, {24'h0, rows[i][13:6]});
            frame(2);
            chk("dchan", dchan_in_first_bslot, rows[i][5]);
            chk("timing", adaptive_timing, rows[i][4]);
            chk("ms_bit", multiframe_bit, rows[i][3]);
            chk("half", frame_half, rows[i][2]);
            chk("aux_framing", auxiliary_framing_bit, rows[i][1]);
            chk("n", n_bit, rows[i][0]);
        end
        bus(1, 8'h08, 32'h20);
        bus(1, 8'h08, 32'h10);
        repeat (8) @(posedge ref_clk);
        chk("staged", adaptive_timing, 0);
        frame(1);
        chk("last_wins", {dchan_in_first_bslot, adaptive_timing}, 2'b01);
        half_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("half_pin", frame_half, 1);
        half_pin <= 1'b0;
        bus(0, 8'h08, 32'h0);
        chk("ctrl_read", rd, 0);
        bus(1, 8'h10, 32'hFF);
        bus(0, 8'h10, 32'h0);
        chk("unmapped", rd, 0);
        bus(1, 8'h08, 32'h80);
        frame(6);
        chk("link_up", link_active, 1);
        chk("locked", frame_locked, 1);
        bus(1, 8'h08, 32'h21);
        good <= 1'b0;
        frame(3);
        chk("hold_lock", frame_locked, 1);
        bus(1, 8'h08, 32'h01);
        frame(2);
        chk("lost_lock", frame_locked, 0);
        good <= 1'b1;
        frame(2);
        chk("two_clean", frame_locked, 0);
        bus(1, 8'h08, 32'hC0);
        frame(3);
        chk("deact_wins", link_active, 0);
        ext_clk_en <= 1'b1;
        bus(1, 8'h08, 32'h23);
        frame(1);
        chk("slave", nt_slave, 1);
        chk("diag_steer", dchan_in_first_bslot, 0);
        ext_clk_en <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("slave_clk", nt_slave, 0);
        bus(1, 8'h08, 32'h09);
        repeat (8) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk) chk("idle", line_transmit, 1);
        bus(1, 8'h08, 32'h05);
        repeat (8) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk) chk("echo", echo_bit, 0);
        bus(1, 8'h08, 32'h11);
        repeat (4) @(posedge ref_clk);
        viol <= 0;
        frame(2);
        chk("no_violation", viol, 0);
        bus(1, 8'h08, 32'h41);
        tx_data_bit <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("near_loop", serial_stream_out, 1);
        // Pin and line levels differ so a wrong path shows
        for (int v = 0; v < 2; v++) begin
            serial_stream_in <= v[0];
            level <= !v[0];
            bus(1, 8'h08, 32'h81);
            repeat (8) @(posedge ref_clk);
            chk("digital_loop", serial_stream_out, v);
            bus(1, 8'h08, 32'hC1);
            repeat (8) @(posedge ref_clk);
            chk("remote_loop", line_transmit, !v[0]);
        end
        // Mid-run reset must clear the loop and test bits
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("reset_diag", {line_violation, line_transmit, serial_stream_out}, 3'b110);
        chk("reset_n_bit", n_bit, 1);
        end_sim();
    end
endmodule
